// File: serial_bus_ctrl.sv
/*
  Controller for the single-master addressed serial bus: shifts an
  eight-bit address with select low, then a byte-multiple payload with
  select high, in write-only, four-wire or shared-line wiring.
  Assumes a user on the same clock drives the command port, an external
  pull-up on the peripheral output and shared lines, and one peripheral
  answering per address.
*/
// Functional notes
// - address low group first, select low
// - select high for data, low ends frame
// - controller samples read bits on rise
// - address field is eight bits
// - payload is whole bytes
// - four-bit address padded in low group
// - write-only uses select, clock, input line
// - four-wire adds separate peripheral output line
// - shared variant uses one data line
// - single controller drives select and clock
// - first read bit position is unreliable
`default_nettype none
`include "serial_ctrl_defines.svh"

module serial_bus_ctrl
  import serial_ctrl_pkg::*;
#(
  parameter int HALF_CYCLES = `LINK_HALF_CYC,
  parameter int GAP_CYCLES = `SELECT_GAP_CYC
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CMD_VALID,
  input wire logic [`ADDR_W-1:0] CMD_ADDR,
  input wire logic CMD_SHORT_ADDR,
  input wire logic CMD_READ,
  input wire logic [`NBYTES_W-1:0] CMD_NBYTES,
  input wire logic CMD_IDLE_HIGH,
  input wire link_mode_t CMD_MODE,
  output logic CMD_READY,
  input wire logic [`BYTE_W-1:0] WR_DATA,
  output logic WR_TAKE,
  output logic [`BYTE_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic DONE,
  output logic READ_REQUEST,
  output logic SELECT_LINE,
  output logic SERIAL_CLOCK_LINE,
  output logic SERIAL_IN_LINE,
  output logic SHARED_DATA_LINE_O,
  output logic SHARED_DATA_LINE_OE,
  input wire logic SHARED_DATA_LINE_I,
  input wire logic PERIPH_OUT_LINE
);

  localparam logic [`TIMER_W-1:0] HALF_LOAD = `TIMER_W'(HALF_CYCLES - 1);
  localparam logic [`TIMER_W-1:0] GAP_LOAD = `TIMER_W'(GAP_CYCLES - 1);
  // counts must fit the timer and leave room for the pin synchroniser
  if (HALF_CYCLES < 4 || HALF_CYCLES >= (1 << `TIMER_W))
    $error("HALF_CYCLES out of range");
  if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << `TIMER_W))
    $error("GAP_CYCLES out of range");
  ctrl_reg_t q;
  ctrl_reg_t d;
  logic [1:0] pins_sync;
  logic tick;
  logic line_bit;

  // peripheral output line and shared line, both synced
  line_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(REF_CLK),
    .rst(RESET),
    .async_in({PERIPH_OUT_LINE, SHARED_DATA_LINE_I}),
    .sync_out(pins_sync)
  );

  // the line that carries peripheral data for a given wiring
  function automatic logic pick_line(link_mode_t m, logic [1:0] s);
    pick_line = (m == MODE_SHARED) ? s[0] : s[1];
  endfunction
  assign tick = (q.tmr == '0);
  assign line_bit = pick_line(q.mode, pins_sync);
  // one next-state process for the whole controller
  always_comb
  begin
    d = q;
    d.wr_take = 1'b0;
    d.rd_valid = 1'b0;
    d.done = 1'b0;
    if (!tick)
      d.tmr = q.tmr - 1'b1;
    case (q.st)
      ST_IDLE:
      begin
        d.sel = 1'b0;
        d.doe = 1'b0;
        // a low line while no frame runs is a read request
        d.req = ~pick_line(CMD_MODE, pins_sync);
        if (CMD_VALID)
        begin
          d.req = 1'b0;
          // short addresses carry filler in the low group
          if (CMD_SHORT_ADDR)
            d.sh = {CMD_ADDR[`GROUP_W-1:0], `ADDR_PAD};
          else
            d.sh = CMD_ADDR;
          d.is_read = CMD_READ;
          d.idle_high = CMD_IDLE_HIGH;
          d.mode = CMD_MODE;
          // zero bytes is not a frame, send one
          d.bytes_left = (CMD_NBYTES == '0) ? `NBYTES_W'(1) : CMD_NBYTES;
          // controller owns the shared line during the address
          d.doe = (CMD_MODE == MODE_SHARED);
          // first address bit goes out with select low
          d.dout = d.sh[0];
          d.clk = 1'b0;
          d.tmr = HALF_LOAD;
          d.st = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        if (tick)
        begin
          d.tmr = HALF_LOAD;
          if (!q.half)
          begin
            // rising edge presents the stable bit to the peripheral
            d.clk = 1'b1;
            d.half = 1'b1;
          end
          // eight address bits, then leave the address phase
          else if (q.bit_idx == `BITIDX_W'(`ADDR_W - 1))
          begin
            // clock returns to the chosen idle level
            d.clk = q.idle_high;
            d.tmr = GAP_LOAD;
            d.st = ST_PRE_SEL;
          end
          else
          begin
            d.bit_idx = q.bit_idx + 1'b1;
            d.sh = q.sh >> 1;
            d.dout = q.sh[1];
            d.clk = 1'b0;
            d.half = 1'b0;
          end
        end
      end
      ST_PRE_SEL:
      begin
        if (tick)
        begin
          // select rises only after every address bit
          d.sel = 1'b1;
          // hand the shared line to the peripheral for reads
          if (q.is_read && q.mode == MODE_SHARED)
            d.doe = 1'b0;
          d.tmr = GAP_LOAD;
          d.st = ST_SEL_WAIT;
        end
      end
      ST_SEL_WAIT:
      begin
        if (tick)
        begin
          d.bit_idx = '0;
          d.half = 1'b0;
          d.clk = 1'b0;
          d.tmr = HALF_LOAD;
          d.st = ST_DATA;
          if (!q.is_read)
          begin
            d.sh = WR_DATA;
            d.dout = WR_DATA[0];
            d.wr_take = 1'b1;
          end
        end
      end
      ST_DATA:
      begin
        if (tick)
        begin
          d.tmr = HALF_LOAD;
          if (!q.half)
          begin
            d.clk = 1'b1;
            d.half = 1'b1;
            // sampled at each rise; first bit not realigned
            if (q.is_read)
              d.sh = {line_bit, q.sh[`BYTE_W-1:1]};
          end
          // payload ends only on a byte boundary
          else if (q.bit_idx == `BITIDX_W'(`BYTE_W - 1))
          begin
            d.rd_data = q.is_read ? q.sh : q.rd_data;
            d.rd_valid = q.is_read;
            d.bytes_left = q.bytes_left - 1'b1;
            d.bit_idx = '0;
            d.half = 1'b0;
            if (q.bytes_left == `NBYTES_W'(1))
            begin
              // stop with the clock at its idle level
              d.clk = q.idle_high;
              d.tmr = GAP_LOAD;
              d.st = ST_HOLD;
            end
            else
            begin
              d.clk = 1'b0;
              if (!q.is_read)
              begin
                d.sh = WR_DATA;
                d.dout = WR_DATA[0];
                d.wr_take = 1'b1;
              end
            end
          end
          else
          begin
            d.bit_idx = q.bit_idx + 1'b1;
            d.clk = 1'b0;
            d.half = 1'b0;
            if (!q.is_read)
            begin
              d.sh = q.sh >> 1;
              d.dout = q.sh[1];
            end
          end
        end
      end
      ST_HOLD:
      begin
        if (tick)
        begin
          d.sel = 1'b0;
          d.doe = 1'b0;
          d.tmr = GAP_LOAD;
          d.st = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // spacing before the next frame may be accepted
        if (tick)
        begin
          d.done = 1'b1;
          d.st = ST_IDLE;
        end
      end
      default:
      begin
        d.st = ST_IDLE;
      end
    endcase
    d.ready = (d.st == ST_IDLE);
  end

  // sole driver of select and clock, held at known levels in reset
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      q <= '0; // idle state and write-only wiring both encode as zero
      q.dout <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // every pin and user output is a flop of the state
  assign CMD_READY = q.ready;
  assign WR_TAKE = q.wr_take;
  assign RD_DATA = q.rd_data;
  assign RD_VALID = q.rd_valid;
  assign DONE = q.done;
  assign READ_REQUEST = q.req;
  assign SELECT_LINE = q.sel;
  assign SERIAL_CLOCK_LINE = q.clk;
  // address and write data share the input line in both wirings
  assign SERIAL_IN_LINE = q.dout;
  assign SHARED_DATA_LINE_O = q.dout;
  assign SHARED_DATA_LINE_OE = q.doe;

endmodule

`default_nettype wire

// File: serial_ctrl_defines.svh
/*
  Constants of the addressed serial bus controller: timing, widths and
  the filler used for short addresses.
  Assumes a reference clock of 250 MHz; counts are derived from it.
*/
`ifndef SERIAL_CTRL_DEFINES_SVH
`define SERIAL_CTRL_DEFINES_SVH

// reference clock rate in MHz
`define REF_CLK_MHZ 250
// half period of the serial clock, ns (least time)
`define LINK_HALF_NS 1000
// wait around select edges and between frames, ns (least time)
`define SELECT_GAP_NS 1000
// least times round up to whole reference cycles
`define NS_TO_CYC(ns) (((ns) * `REF_CLK_MHZ + 999) / 1000)
`define LINK_HALF_CYC `NS_TO_CYC(`LINK_HALF_NS)
`define SELECT_GAP_CYC `NS_TO_CYC(`SELECT_GAP_NS)

// address field on the link, and its two nibble groups
`define ADDR_W 8
`define GROUP_W 4
// filler sent in the low group for a four-bit address
`define ADDR_PAD 4'h0
// payload is counted in bytes
`define BYTE_W 8
`define NBYTES_W 8
`define BITIDX_W 3
`define TIMER_W 16

`endif

// File: serial_ctrl_pkg.sv
/*
  Types of the addressed serial bus controller.
  Assumes serial_ctrl_defines.svh is on the include path.
*/
`default_nettype none
`include "serial_ctrl_defines.svh"

package serial_ctrl_pkg;

  // wiring variant of the link
  typedef enum logic [1:0] {
    MODE_WRITE_ONLY,
    MODE_FOUR_WIRE,
    MODE_SHARED
  } link_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PRE_SEL,
    ST_SEL_WAIT,
    ST_DATA,
    ST_HOLD,
    ST_GAP
  } ctrl_state_t;

  // whole state of the controller
  typedef struct packed {
    ctrl_state_t st;
    logic [`TIMER_W-1:0] tmr;
    logic [`BITIDX_W-1:0] bit_idx;
    logic half;
    logic [`NBYTES_W-1:0] bytes_left;
    logic [`BYTE_W-1:0] sh;
    logic is_read;
    logic idle_high;
    link_mode_t mode;
    logic clk;
    logic sel;
    logic dout;
    logic doe;
    logic ready;
    logic wr_take;
    logic rd_valid;
    logic [`BYTE_W-1:0] rd_data;
    logic done;
    logic req;
  } ctrl_reg_t;

endpackage

`default_nettype wire

// File: line_sync.sv
/*
  Two-flop synchroniser for pins that arrive from outside the clock
  domain. Assumes each bit is an independent level.
*/
`default_nettype none

module line_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // a zero-width synchroniser carries nothing
  if (WIDTH < 1)
    $error("WIDTH must be at least 1");

  // pins idle high through their pull-ups, so reset to high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// File: serial_ctrl_chk_assertions.sv
/* port checker for serial_bus_ctrl, bound onto every instance.
   assumes reset is held before the first command is offered. */
`default_nettype none
`include "serial_ctrl_defines.svh"
module serial_ctrl_chk #(
  parameter int HALF_CYCLES = `LINK_HALF_CYC,
  parameter int GAP_CYCLES = `SELECT_GAP_CYC
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire logic [`BYTE_W-1:0] WR_DATA,
  input wire logic WR_TAKE,
  input wire logic RD_VALID,
  input wire logic DONE,
  input wire logic READ_REQUEST,
  input wire logic SELECT_LINE,
  input wire logic SERIAL_CLOCK_LINE,
  input wire logic SERIAL_IN_LINE,
  input wire logic SHARED_DATA_LINE_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  // the hold check needs four cycles in every half period
  if (HALF_CYCLES < 4 || GAP_CYCLES < 1)
    $error("link timing too short for these checks");
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  // the hold repetition stays at 4, the least legal half period
  a_addr_sel_low:
    assert property (CMD_VALID && CMD_READY |=> !SELECT_LINE [*8])
    else $error("select high during address");
  a_idle_quiet:
    assert property (CMD_READY |-> !SELECT_LINE && !SHARED_DATA_LINE_OE)
    else $error("select or shared drive while idle");
  a_done_ends:
    assert property (DONE |-> (CMD_READY && !SELECT_LINE) ##1 !DONE)
    else $error("done without frame end");
  a_sel_clk_still:
    assert property ($changed(SELECT_LINE) |-> $stable(SERIAL_CLOCK_LINE))
    else $error("clock moved at select edge");
  a_bit_hold:
    assert property ($rose(SERIAL_CLOCK_LINE) |-> $stable(SERIAL_IN_LINE) [*4])
    else $error("data moved around clock rise");
  a_take_data:
    assert property (WR_TAKE |-> (SELECT_LINE &&
      SERIAL_IN_LINE == $past(WR_DATA[0])) ##1 !WR_TAKE)
    else $error("write byte not launched");
  a_rd_in_frame:
    assert property (RD_VALID |-> (SELECT_LINE && !CMD_READY) ##1 !RD_VALID)
    else $error("read byte outside data phase");
  a_req_idle:
    assert property (READ_REQUEST |-> CMD_READY || $past(CMD_READY))
    else $error("read request while busy");
  c_read: cover property (RD_VALID);
  c_write: cover property (WR_TAKE);
  c_request: cover property (READ_REQUEST);
endmodule
bind serial_bus_ctrl serial_ctrl_chk #(
  .HALF_CYCLES(HALF_CYCLES),
  .GAP_CYCLES(GAP_CYCLES)
) chk (
  .REF_CLK(REF_CLK),
  .RESET(RESET),
  .CMD_VALID(CMD_VALID),
  .CMD_READY(CMD_READY),
  .WR_DATA(WR_DATA),
  .WR_TAKE(WR_TAKE),
  .RD_VALID(RD_VALID),
  .DONE(DONE),
  .READ_REQUEST(READ_REQUEST),
  .SELECT_LINE(SELECT_LINE),
  .SERIAL_CLOCK_LINE(SERIAL_CLOCK_LINE),
  .SERIAL_IN_LINE(SERIAL_IN_LINE),
  .SHARED_DATA_LINE_OE(SHARED_DATA_LINE_OE)
);
`default_nettype wire

// File: periph_model.sv
/* behavioural peripheral on the addressed serial bus.
   assumes the bench resolves its open-drain output with a pull-up. */
`default_nettype none
module periph_model #(
  parameter logic [7:0] WR_ADDR = 8'hA0,
  parameter logic [7:0] RD_ADDR = 8'h3C
) (
  input wire logic sel,
  input wire logic sclk,
  input wire logic din,
  input wire logic req,
  input wire logic [15:0] tx,
  output logic pull_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] addr = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx [4];
  logic rd = 1'b0;
  int nbit = 0;
  int obit = 0;
  // restart at select edges
  // bit count kept after the frame so the bench can read it
  always @(sel)
  begin
    obit = 0;
    rd = sel && addr == RD_ADDR;
    if (sel)
      nbit = 0;
  end
  always @(posedge sclk)
  begin
    if (!sel)
      addr = {din, addr[7:1]};
    else if (addr == WR_ADDR)
    begin
      sh = {din, sh[7:1]};
      nbit++;
      if (nbit % 8 == 0)
        rx[(nbit / 8 - 1) % 4] = sh;
    end
  end
  always @(negedge sclk)
    if (rd)
      obit++;
  assign pull_low = rd ? (obit < 16 && !tx[obit]) : (!sel && req);
endmodule
`default_nettype wire

// File: tb.sv
/* self-checking bench for serial_bus_ctrl with a peripheral model.
   assumes short link timing: half bit of 8 cycles, gap of 4. */
`default_nettype none
`define CHK(nm, e, s) \
  begin \
    checked++; \
    if ((s) !== (e)) \
    begin \
      n_mismatch++; \
      $display("mismatch %s exp %0h got %0h", nm, e, s); \
    end \
  end
module tb
  import serial_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst = 1;
  logic cmd_valid = 0;
  logic [7:0] cmd_addr = 0;
  logic short_a = 0;
  logic cmd_read = 0;
  logic [7:0] nbytes = 1;
  logic idle_high = 0;
  link_mode_t mode = MODE_FOUR_WIRE;
  logic [7:0] wr_data = 0;
  logic req = 0;
  logic [15:0] tx = 0;
  logic ready, wr_take, rd_valid, done, rd_req, sel, sclk, sin, so, soe;
  logic [7:0] rd_data;
  logic pl;
  logic [7:0] wq [4];
  logic [7:0] rq [4];
  int n_mismatch = 0;
  int checked = 0;
  // pulled-up lines: a released line reads high
  wire shm = mode == MODE_SHARED;
  wire pin_sh = (!soe | so) & !(shm & pl);
  wire pin_do = !(mode == MODE_FOUR_WIRE & pl);
  wire p_din = shm ? pin_sh : sin;
  serial_bus_ctrl #(.HALF_CYCLES(8), .GAP_CYCLES(4)) DUT (
    .REF_CLK(clk), .RESET(rst), .CMD_VALID(cmd_valid),
    .CMD_ADDR(cmd_addr), .CMD_SHORT_ADDR(short_a), .CMD_READ(cmd_read),
    .CMD_NBYTES(nbytes), .CMD_IDLE_HIGH(idle_high), .CMD_MODE(mode),
    .CMD_READY(ready), .WR_DATA(wr_data), .WR_TAKE(wr_take),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .DONE(done),
    .READ_REQUEST(rd_req), .SELECT_LINE(sel), .SERIAL_CLOCK_LINE(sclk),
    .SERIAL_IN_LINE(sin), .SHARED_DATA_LINE_O(so),
    .SHARED_DATA_LINE_OE(soe), .SHARED_DATA_LINE_I(pin_sh),
    .PERIPH_OUT_LINE(pin_do));
  periph_model P (.sel(sel), .sclk(sclk), .din(p_din), .req(req),
    .tx(tx), .pull_low(pl));
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one frame; inputs move on falling edges only
  task automatic frame(input link_mode_t m, input logic r,
    input logic [7:0] a, input logic s, input logic [7:0] n, input logic ih);
    int k;
    int nr;
    int w;
    @(negedge clk);
    mode = m;
    cmd_read = r;
    cmd_addr = a;
    short_a = s;
    nbytes = n;
    idle_high = ih;
    wr_data = wq[0];
    k = 0;
    nr = 0;
    w = 0;
    cmd_valid = 1;
    // hold the request until ready is seen ahead of a rising edge
    while (ready !== 1'b1 && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    cmd_valid = 0;
    while (done !== 1'b1 && k < 4000)
    begin
      @(negedge clk);
      k++;
      if (rd_valid === 1'b1)
      begin
        rq[nr % 4] = rd_data;
        nr++;
      end
      if (wr_take === 1'b1)
      begin
        w++;
        wr_data = wq[w % 4];
      end
    end
    `CHK("frame end", 1'b1, done)
  endtask
  task automatic t_write_4w;
    wq = '{8'hA5, 8'h3C, 8'h00, 8'h00};
    frame(MODE_FOUR_WIRE, 0, 8'hA0, 0, 2, 0);
    `CHK("addr", 8'hA0, P.addr)
    `CHK("bits", 16, P.nbit)
    `CHK("byte0", 8'hA5, P.rx[0])
    `CHK("byte1", 8'h3C, P.rx[1])
  endtask
  task automatic t_short_shared;
    wq = '{8'h81, 8'h00, 8'h00, 8'h00};
    frame(MODE_SHARED, 0, 8'h5A, 1, 1, 1);
    `CHK("short addr", 8'hA0, P.addr)
    `CHK("shared byte", 8'h81, P.rx[0])
  endtask
  task automatic t_write_only;
    wq = '{8'h7E, 8'h00, 8'h00, 8'h00};
    frame(MODE_WRITE_ONLY, 0, 8'hA0, 0, 0, 0);
    `CHK("wo bits", 8, P.nbit)
    `CHK("wo byte", 8'h7E, P.rx[0])
  endtask
  task automatic t_read_4w;
    tx = 16'h96E1;
    frame(MODE_FOUR_WIRE, 1, 8'h3C, 0, 2, 0);
    `CHK("rd byte0", 8'hE1, rq[0])
    `CHK("rd byte1", 8'h96, rq[1])
  endtask
  // idle-high stop slides the read by one bit; bit 0 of tx is lost
  task automatic t_read_shared_ih;
    tx = 16'h01E1;
    frame(MODE_SHARED, 1, 8'h3C, 0, 1, 1);
    `CHK("rd shifted", 8'hF0, rq[0])
  endtask
  task automatic t_other_addr;
    frame(MODE_FOUR_WIRE, 0, 8'h33, 0, 1, 0);
    `CHK("ignored", 0, P.nbit)
    `CHK("released", 1'b1, pin_do)
  endtask
  task automatic t_request;
    mode = MODE_FOUR_WIRE;
    req = 1;
    repeat (6) @(negedge clk);
    `CHK("request", 1'b1, rd_req)
    // the shared wiring watches the shared line instead
    mode = MODE_SHARED;
    repeat (6) @(negedge clk);
    `CHK("shared request", 1'b1, rd_req)
    req = 0;
    repeat (6) @(negedge clk);
    `CHK("no request", 1'b0, rd_req)
  endtask
  initial
  begin
    forever #2 clk = ~clk;
  end
  // watchdog: whole run needs well under 10000 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_write_4w();
    t_short_shared();
    t_write_only();
    t_read_4w();
    t_read_shared_ih();
    t_other_addr();
    t_request();
    close_out();
  end
endmodule
`default_nettype wire
